// ### gpio_abc_defs.svh
// constants for the port A/B/C data register block
// assumes a 32-bit AHB-Lite bus and modes supplied by the pin function controller
`ifndef GPIO_ABC_DEFS_SVH
`define GPIO_ABC_DEFS_SVH

`define PORT_WIDTH          8
`define PORT_COUNT          3
`define MODE_WIDTH          16
`define DATA_RESET          8'h00
`define SYNC_RESET          8'h00
`define RDATA_RESET         32'h0000_0000

// printed offsets are register indices; byte address is four times the index
`define PORT_A_DATA_IDX     32'h0400_0120
`define PORT_B_DATA_IDX     32'h0400_0122
`define PORT_C_DATA_IDX     32'h0400_0124
// area bits above this are ignored so the uncached alias decodes too
`define DEC_MSB             28
`define DEC_LSB             2
`define IDX_MSB             26

`define PORT_A_SEL          2'h0
`define PORT_B_SEL          2'h1
`define PORT_C_SEL          2'h2

`define MODE_ALT            2'h0
`define MODE_OUT            2'h1
`define MODE_IN_PULLUP      2'h2
`define MODE_IN_NOPULL      2'h3

`define HTRANS_ACTIVE_BIT   1
`define HRESP_OKAY          1'b0

`endif

// ### gpio_abc_pkg.sv
// types shared by the port A/B/C data register block
// assumes gpio_abc_defs.svh for the numeric constants
package gpio_abc_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ,
        BUS_RDONE
    } bus_state_t;

    typedef struct packed {
        logic       hit;
        logic [1:0] port;
    } addr_hit_t;

    typedef logic [7:0] port_byte_t;

endpackage

// ### gpio_abc_props.sv
// checker for the port A/B/C data register block
// assumes it is bound to gpio_port_data_regs_abc and sees only its ports
`timescale 1ns/1ps
`include "gpio_abc_defs.svh"
module gpio_abc_props (
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic [15:0] PORT_A_MODE,
    input wire logic [15:0] PORT_C_MODE,
    input wire logic [7:0]  PORT_A_PIN_OUT,
    input wire logic [7:0]  PORT_A_PIN_OE,
    input wire logic [7:0]  PORT_C_PULLUP_EN
);
    localparam logic [31:0] IDX_A = `PORT_A_DATA_IDX;
    logic taken;
    logic a_dp_reg;

    function automatic logic [7:0] mask_of(input logic [15:0] m, input logic [1:0] code);
        for (int n = 0; n < 8; n++) begin
            mask_of[n] = (m[2*n+:2] == code);
        end
    endfunction

    assign taken = HSEL & HREADY & HTRANS[1];
    // marks the data phase of a write to port A, when the stored byte may change
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            a_dp_reg <= 1'b0;
        end else begin
            a_dp_reg <= taken && HWRITE && HADDR[28:2] == IDX_A[26:0];
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence rd_taken;
        taken && !HWRITE;
    endsequence
    sequence wr_a_taken;
        taken && HWRITE && HADDR[28:2] == IDX_A[26:0];
    endsequence

    chk_read_wait: assert property (rd_taken |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read data phase did not take one wait state");
    chk_write_nowait: assert property (taken && HWRITE |=> HREADYOUT)
        else $error("write data phase stalled");
    chk_a_write_lands: assert property (wr_a_taken ##1 1'b1 |=> PORT_A_PIN_OUT == $past(HWDATA[7:0]))
        else $error("port A output does not hold the written byte");
    chk_a_out_steady: assert property (!a_dp_reg |=> $stable(PORT_A_PIN_OUT))
        else $error("port A output changed without a write");
    chk_oe_by_mode: assert property (PORT_A_PIN_OE == mask_of(PORT_A_MODE, `MODE_OUT))
        else $error("port A drive enable does not follow output mode");
    chk_pullup_mode: assert property (PORT_C_PULLUP_EN == mask_of(PORT_C_MODE, `MODE_IN_PULLUP))
        else $error("port C pull-up does not follow its mode");
    chk_resp_okay: assert property (HRESP == `HRESP_OKAY)
        else $error("response is not okay");
    chk_rdata_upper: assert property (HRDATA[31:8] == '0)
        else $error("read data above the low byte is not zero");
endmodule

// ### gpio_port_data_regs_abc.sv
// data registers of general purpose ports A, B and C on an AHB-Lite slave
// assumes pin modes come from the pin function controller on the same clock
// Functional notes
// - each port has one 8-bit data register whose bit n belongs to pin n.
// - each pin takes a two-bit mode: 00 alternate, 01 output, 10 input with pull-up, 11 input without.
// - in alternate mode a write stores the bit without touching the pin and a read returns the stored bit.
// - in output mode the pin is driven with the stored bit and a read returns the stored bit.
// - in either input mode a read returns the pin level and a write only updates the stored bit.
// - the pin pull-up is on in input-with-pull-up mode and off in every other mode.
// - power-on reset clears all three data registers to zero.
// - manual reset, sleep and standby leave the data registers unchanged.
// - after power-on reset port C reads return pin levels because its mode defaults to input with pull-up.
// - the registers decode at consecutive even locations, reachable through the cached or uncached alias.
`timescale 1ns/1ps
`include "gpio_abc_defs.svh"
module gpio_port_data_regs_abc (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    // modes from the pin function controller, two bits per pin
    input  wire logic [15:0] PORT_A_MODE,
    input  wire logic [15:0] PORT_B_MODE,
    input  wire logic [15:0] PORT_C_MODE,
    // low-power and manual reset status, held for visibility only
    input  wire logic        MANUAL_RST_N,
    input  wire logic        LOW_POWER,
    // port pins as input, output, output enable and pull-up enable
    input  wire logic [7:0]  PORT_A_PIN_IN,
    output logic [7:0]       PORT_A_PIN_OUT,
    output logic [7:0]       PORT_A_PIN_OE,
    output logic [7:0]       PORT_A_PULLUP_EN,
    input  wire logic [7:0]  PORT_B_PIN_IN,
    output logic [7:0]       PORT_B_PIN_OUT,
    output logic [7:0]       PORT_B_PIN_OE,
    output logic [7:0]       PORT_B_PULLUP_EN,
    input  wire logic [7:0]  PORT_C_PIN_IN,
    output logic [7:0]       PORT_C_PIN_OUT,
    output logic [7:0]       PORT_C_PIN_OE,
    output logic [7:0]       PORT_C_PULLUP_EN,
    output logic             RETAIN_ACTIVE
);

    // per-pin mode decode
    function automatic logic [1:0] pin_mode(
        input logic [15:0] mode_word,
        input int          bit_n
    );
        pin_mode = mode_word[2*bit_n +: 2];
    endfunction

    function automatic gpio_abc_pkg::port_byte_t drive_mask(
        input logic [15:0] mode_word
    );
        gpio_abc_pkg::port_byte_t m;
        m = '0;
        for (int n = 0; n < `PORT_WIDTH; n++) begin
            m[n] = (pin_mode(mode_word, n) == `MODE_OUT);
        end
        return m;
    endfunction

    function automatic gpio_abc_pkg::port_byte_t pullup_mask(
        input logic [15:0] mode_word
    );
        gpio_abc_pkg::port_byte_t m;
        m = '0;
        for (int n = 0; n < `PORT_WIDTH; n++) begin
            m[n] = (pin_mode(mode_word, n) == `MODE_IN_PULLUP);
        end
        return m;
    endfunction

    // input modes read the pin, alternate and output read the store
    function automatic gpio_abc_pkg::port_byte_t read_merge(
        input logic [15:0]              mode_word,
        input gpio_abc_pkg::port_byte_t stored,
        input gpio_abc_pkg::port_byte_t level
    );
        gpio_abc_pkg::port_byte_t r;
        r = '0;
        for (int n = 0; n < `PORT_WIDTH; n++) begin
            case (pin_mode(mode_word, n))
                `MODE_ALT:       r[n] = stored[n];
                `MODE_OUT:       r[n] = stored[n];
                `MODE_IN_PULLUP: r[n] = level[n];
                `MODE_IN_NOPULL: r[n] = level[n];
                default:         r[n] = stored[n];
            endcase
        end
        return r;
    endfunction

    // area bits are dropped so both the cached and uncached alias hit
    function automatic gpio_abc_pkg::addr_hit_t decode_addr(
        input logic [31:0] addr
    );
        gpio_abc_pkg::addr_hit_t d;
        logic [26:0]             word;
        logic [31:0]             idx_a;
        logic [31:0]             idx_b;
        logic [31:0]             idx_c;
        word  = addr[`DEC_MSB:`DEC_LSB];
        idx_a = `PORT_A_DATA_IDX;
        idx_b = `PORT_B_DATA_IDX;
        idx_c = `PORT_C_DATA_IDX;
        d.hit  = 1'b0;
        d.port = `PORT_A_SEL;
        if (word == idx_a[`IDX_MSB:0]) begin
            d.hit  = 1'b1;
            d.port = `PORT_A_SEL;
        end else if (word == idx_b[`IDX_MSB:0]) begin
            d.hit  = 1'b1;
            d.port = `PORT_B_SEL;
        end else if (word == idx_c[`IDX_MSB:0]) begin
            d.hit  = 1'b1;
            d.port = `PORT_C_SEL;
        end
        return d;
    endfunction

    // state
    gpio_abc_pkg::bus_state_t   state_reg;
    gpio_abc_pkg::bus_state_t   state_next;
    gpio_abc_pkg::addr_hit_t    target_reg;
    gpio_abc_pkg::addr_hit_t    addr_dec;
    gpio_abc_pkg::port_byte_t   port_a_data_reg;
    gpio_abc_pkg::port_byte_t   port_b_data_reg;
    gpio_abc_pkg::port_byte_t   port_c_data_reg;
    gpio_abc_pkg::port_byte_t   read_byte;
    logic [31:0]                hrdata_reg;
    logic                       addr_phase;
    logic                       retain_reg;

    pin_sync_if psif ();

    assign psif.raw = {PORT_C_PIN_IN, PORT_B_PIN_IN, PORT_A_PIN_IN};

    pin_level_sync u_sync (
        .clk   (MCLK),
        .rst_n (RST_N),
        .sif   (psif.sampler)
    );

    // a valid address phase is one with htrans nonseq or seq while ready
    assign addr_phase = HSEL && HREADY && HTRANS[`HTRANS_ACTIVE_BIT];
    assign addr_dec   = decode_addr(HADDR);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            gpio_abc_pkg::BUS_IDLE,
            gpio_abc_pkg::BUS_WRITE,
            gpio_abc_pkg::BUS_RDONE: begin
                if (addr_phase && HWRITE) begin
                    state_next = gpio_abc_pkg::BUS_WRITE;
                end else if (addr_phase) begin
                    state_next = gpio_abc_pkg::BUS_READ;
                end else begin
                    state_next = gpio_abc_pkg::BUS_IDLE;
                end
            end
            gpio_abc_pkg::BUS_READ: begin
                state_next = gpio_abc_pkg::BUS_RDONE;
            end
            default: begin
                state_next = gpio_abc_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= gpio_abc_pkg::BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // address phase capture; only taken when the slave is ready
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            target_reg <= '0;
        end else if (addr_phase && state_reg != gpio_abc_pkg::BUS_READ) begin
            target_reg <= addr_dec;
        end
    end

    // only the power-on reset clears the store; manual reset and low power never touch it
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            port_a_data_reg <= `DATA_RESET;
            port_b_data_reg <= `DATA_RESET;
            port_c_data_reg <= `DATA_RESET;
        end else if (state_reg == gpio_abc_pkg::BUS_WRITE && target_reg.hit) begin
            // writes always land in the store, whatever the pin mode
            case (target_reg.port)
                `PORT_A_SEL: port_a_data_reg <= HWDATA[7:0];
                `PORT_B_SEL: port_b_data_reg <= HWDATA[7:0];
                `PORT_C_SEL: port_c_data_reg <= HWDATA[7:0];
                default: begin
                end
            endcase
        end
    end

    // read value built from the synchronised levels, never the raw pins
    always_comb begin
        read_byte = '0;
        if (target_reg.hit) begin
            case (target_reg.port)
                `PORT_A_SEL: read_byte = read_merge(PORT_A_MODE, port_a_data_reg, psif.level[0]);
                `PORT_B_SEL: read_byte = read_merge(PORT_B_MODE, port_b_data_reg, psif.level[1]);
                // default input-with-pull-up mode makes this return pin levels after reset
                `PORT_C_SEL: read_byte = read_merge(PORT_C_MODE, port_c_data_reg, psif.level[2]);
                default:     read_byte = '0;
            endcase
        end
    end

    // one wait state buys a registered read path; unmapped reads return zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hrdata_reg <= `RDATA_RESET;
        end else if (state_reg == gpio_abc_pkg::BUS_READ) begin
            hrdata_reg <= {24'h00_0000, read_byte};
        end
    end

    // mirrors the retention condition so software tracing can see it
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            retain_reg <= 1'b0;
        end else begin
            retain_reg <= !MANUAL_RST_N || LOW_POWER;
        end
    end

    assign HREADYOUT = (state_reg != gpio_abc_pkg::BUS_READ);
    assign HRESP     = `HRESP_OKAY;
    assign HRDATA    = hrdata_reg;

    // pin values come straight from the store; enable only in output mode
    assign PORT_A_PIN_OUT   = port_a_data_reg;
    assign PORT_B_PIN_OUT   = port_b_data_reg;
    assign PORT_C_PIN_OUT   = port_c_data_reg;
    assign PORT_A_PIN_OE    = drive_mask(PORT_A_MODE);
    assign PORT_B_PIN_OE    = drive_mask(PORT_B_MODE);
    assign PORT_C_PIN_OE    = drive_mask(PORT_C_MODE);
    assign PORT_A_PULLUP_EN = pullup_mask(PORT_A_MODE);
    assign PORT_B_PULLUP_EN = pullup_mask(PORT_B_MODE);
    assign PORT_C_PULLUP_EN = pullup_mask(PORT_C_MODE);
    assign RETAIN_ACTIVE    = retain_reg;

endmodule

// ### gpio_port_data_regs_abc_bench.sv
// self-checking bench for the port A/B/C data register block
// assumes an AHB-Lite master in this module and the pin model on the far side
`timescale 1ns/1ps
`include "gpio_abc_defs.svh"
module gpio_port_data_regs_abc_bench;
    localparam logic [31:0] ADDR_A = `PORT_A_DATA_IDX * 4;
    localparam logic [31:0] ADDR_B = `PORT_B_DATA_IDX * 4;
    localparam logic [31:0] ADDR_C = `PORT_C_DATA_IDX * 4;
    logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, manual_rst_n, low_power, retain;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [15:0] mode_a, mode_b, mode_c;
    logic [23:0] pin_out, pin_oe, pull_en, ext_val, ext_en, level;
    int          mismatches, samples_checked;

    gpio_port_data_regs_abc dut (.MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRESP(hresp), .HRDATA(hrdata), .PORT_A_MODE(mode_a), .PORT_B_MODE(mode_b), .PORT_C_MODE(mode_c),
        .MANUAL_RST_N(manual_rst_n), .LOW_POWER(low_power), .RETAIN_ACTIVE(retain),
        .PORT_A_PIN_IN(level[7:0]), .PORT_A_PIN_OUT(pin_out[7:0]), .PORT_A_PIN_OE(pin_oe[7:0]),
        .PORT_A_PULLUP_EN(pull_en[7:0]), .PORT_B_PIN_IN(level[15:8]), .PORT_B_PIN_OUT(pin_out[15:8]),
        .PORT_B_PIN_OE(pin_oe[15:8]), .PORT_B_PULLUP_EN(pull_en[15:8]), .PORT_C_PIN_IN(level[23:16]),
        .PORT_C_PIN_OUT(pin_out[23:16]), .PORT_C_PIN_OE(pin_oe[23:16]), .PORT_C_PULLUP_EN(pull_en[23:16]));
    pin_pad_model pads (.clk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
        .ext_val(ext_val), .ext_en(ext_en), .level(level));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic results();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ready is judged 1 ns after the previous edge, ahead of the edge that samples it; read data is taken there too
    task automatic wait_ready(output logic [31:0] rdata);
        int n;
        #1;
        for (n = 0; hreadyout !== 1'b1; n++) begin
            if (n > 20) begin
                mismatches++;
                results();
            end
            @(posedge mclk);
            #1;
        end
        rdata = hrdata;
        @(posedge mclk);
    endtask

    task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready(rdata);
        htrans <= 2'h0;
        hwdata <= wdata;
        wait_ready(rdata);
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] d;
        xfer(addr, 1'b1, data, d);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        xfer(addr, 1'b0, 32'h0000_0000, d);
        check(d, exp);
    endtask

    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, low_power, ext_val, ext_en} = '0;
        {mode_a, mode_b, mismatches, samples_checked} = '0;
        manual_rst_n = 1'b1;
        mode_c = 16'hAAAA;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ADDR_A, 32'h0000_0000);
        rd(ADDR_B, 32'h0000_0000);
        rd(ADDR_C, 32'h0000_00FF);
        rd(ADDR_A + 4, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            mode_a <= {8{m[1:0]}};
            ext_val[7:0] <= 8'h3C;
            ext_en[7:0] <= {8{m == 3}};
            // a different byte per mode so a write that never landed shows up
            wr(ADDR_A, 32'hFFFF_FFA0 | m);
            #1;
            check(pin_out[7:0], 32'h0000_00A0 | m);
            check(pin_oe[7:0], (m == 1) ? 32'h0000_00FF : 32'h0000_0000);
            check(pull_en[7:0], (m == 2) ? 32'h0000_00FF : 32'h0000_0000);
            repeat (2) @(posedge mclk);
            rd(ADDR_A, (m < 2) ? 32'h0000_00A0 | m : (m == 2) ? 32'h0000_00FF : 32'h0000_003C);
        end
        // the last write went in while the pins were inputs; alternate mode reads the store back
        mode_a <= 16'h0000;
        mode_b <= 16'h5555;
        rd(ADDR_A, 32'h0000_00A3);
        wr(ADDR_B | 32'h8000_0000, 32'h0000_005A);
        wr(ADDR_C, 32'h0000_0081);
        #1;
        check(pin_out[23:8], 32'h0000_815A);
        check(pin_oe[23:8], 32'h0000_00FF);
        check(pull_en[23:8], 32'h0000_FF00);
        @(posedge mclk);
        manual_rst_n <= 1'b0;
        low_power <= 1'b1;
        repeat (4) @(posedge mclk);
        check(retain, 32'h0000_0001);
        manual_rst_n <= 1'b1;
        low_power <= 1'b0;
        rd(ADDR_B, 32'h0000_005A);
        check(retain, 32'h0000_0000);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(ADDR_B, 32'h0000_0000);
        results();
    end
endmodule

bind gpio_port_data_regs_abc gpio_abc_props chk (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .PORT_A_MODE(PORT_A_MODE), .PORT_C_MODE(PORT_C_MODE),
    .PORT_A_PIN_OUT(PORT_A_PIN_OUT), .PORT_A_PIN_OE(PORT_A_PIN_OE), .PORT_C_PULLUP_EN(PORT_C_PULLUP_EN));

// ### pin_level_sync.sv
// two-flop synchroniser for all port pin input levels
// assumes raw pin levels are asynchronous to clk
`timescale 1ns/1ps
`include "gpio_abc_defs.svh"
module pin_level_sync (
    input wire logic      clk,
    input wire logic      rst_n,
    pin_sync_if.sampler   sif
);
    logic [2:0][7:0] stage1_reg;
    logic [2:0][7:0] stage2_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= {`PORT_COUNT{`SYNC_RESET}};
            stage2_reg <= {`PORT_COUNT{`SYNC_RESET}};
        end else begin
            stage1_reg <= sif.raw;
            stage2_reg <= stage1_reg;
        end
    end

    assign sif.level = stage2_reg;
endmodule

// ### pin_pad_model.sv
// external pins of ports A, B and C: resolves each wire from all drivers
// assumes a bench-controlled external driver per pin; undriven pins float unless pulled up
`timescale 1ns/1ps
module pin_pad_model (
    input wire logic        clk,
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    input wire logic [23:0] pull_en,
    input wire logic [23:0] ext_val,
    input wire logic [23:0] ext_en,
    output logic     [23:0] level
);
    logic [23:0] float_reg = 24'h00_5555;

    // a floating pin must not hold its last value, so it toggles every cycle
    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int n = 0; n < 24; n++) begin
            if (pin_oe[n]) begin
                level[n] = pin_out[n];
            end else if (ext_en[n]) begin
                level[n] = ext_val[n];
            end else if (pull_en[n]) begin
                level[n] = 1'b1;
            end else begin
                level[n] = float_reg[n];
            end
        end
    end
endmodule

// ### pin_sync_if.sv
// carrier between the register block and its pin level synchroniser
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
interface pin_sync_if;
    logic [2:0][7:0] raw;
    logic [2:0][7:0] level;

    modport sampler (
        input  raw,
        output level
    );

    modport user (
        output raw,
        input  level
    );
endinterface
